// *** pkg/sbf_pkg.sv ***
// Shared constants and types for the serial bus frame signalling slave
package sbf_pkg;
    localparam int unsigned BYTE_BITS   = 8;
    localparam int unsigned DONE_EDGE   = 9;
    localparam int unsigned FIFO_DEPTH  = 8;
    localparam logic [3:0]  BIT_ZERO    = 4'h0;
    localparam logic [3:0]  BIT_ONE     = 4'h1;
    localparam logic [3:0]  BIT_ACK     = 4'h8;
    localparam logic [3:0]  BIT_DONE    = 4'h9;
    localparam logic [7:0]  ALL_ONES    = 8'hff;

    // Byte type as told apart by the markers before it
    typedef enum logic [1:0] {
        KIND_DATA    = 2'h0,
        KIND_COMMAND = 2'h1,
        KIND_ADDRESS = 2'h2
    } sbf_kind_t;

    typedef struct packed {
        sbf_kind_t  kind;
        logic [7:0] value;
    } sbf_byte_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_SHIFT = 4'b0010,
        ST_ACK   = 4'b0100,
        ST_BUSY  = 4'b1000
    } sbf_state_t;
endpackage

// *** rtl/sbf_fifo.sv ***
// Receive byte FIFO with parameterised width and depth
`timescale 1ns/100ps
`default_nettype none
module sbf_fifo #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    wire              doWrite = inValid && inReady;
    wire              doRead  = outValid && outReady;

    assign inReady  = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];

    always_ff @(posedge ref_clk) begin
        if (doWrite) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (doWrite) wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            if (doRead)  rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            count_q <= count_q + (AW+1)'(doWrite) - (AW+1)'(doRead);
        end
    end
endmodule
`default_nettype wire

// *** rtl/sbf_slave.sv ***
// Slave end of the clocked two-line serial bus with frame markers
//
// What this block does
// - With busy enabled and wakeup off, the slave holds the data line low right after its acknowledge.
// - The slave lets the line float high for ready before and after a byte; ready follows busy-enable cleared or a shift register write.
// - An address byte is eight clocked bits that follow a bus-release marker and a command marker.
// - A command byte is eight clocked bits that follow a command marker without bus-release.
// - A data byte is eight clocked bits with no command marker before it.
// - With wakeup off, the done flag rises at the ninth rising serial clock edge of each byte.
// - With wakeup on, the byte is an address and the done flag rises only on a slave address match.
// - After receiving a byte the slave drives the line low for one serial clock as acknowledge.
// - A data line change while the serial clock is high is a marker, not data.
`timescale 1ns/100ps
`default_nettype none
module sbf_slave
    import sbf_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       serialClockPin,
    input  wire logic       busDataLineIn,
    output logic            busDataLineOut,
    output logic            busDataLineOen,
    input  wire logic       serialUnitEnableBit,
    input  wire logic       busyEnableBit,
    input  wire logic       wakeupSelectBit,
    input  wire logic [7:0] slaveAddressRegister,
    input  wire logic [7:0] shiftRegisterWrData,
    input  wire logic       shiftRegisterWrite,
    output logic [7:0]      shiftRegister,
    output logic            transferDoneFlag,
    output logic            busReleaseMarker,
    output logic            commandMarker,
    output logic            addressMatch,
    output logic [9:0]      rxData,
    output logic            rxValid,
    input  wire logic       rxReady,
    output logic            rxOverflow
);
    // Three-stage samplers; decisions use stages two and three only
    logic [2:0] sckSync_q;
    logic [2:0] sdaSync_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sckSync_q <= 3'h7;
            sdaSync_q <= 3'h7;
        end else begin
            sckSync_q <= {sckSync_q[1:0], serialClockPin};
            sdaSync_q <= {sdaSync_q[1:0], busDataLineIn};
        end
    end

    // A pin change counts once stages two and three agree, so a glitch
    // that reaches only stage two never makes an edge
    logic sckLevel_q;
    logic sdaLevel_q;
    wire  sckAgree = (sckSync_q[1] == sckSync_q[2]);
    wire  sdaAgree = (sdaSync_q[1] == sdaSync_q[2]);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sckLevel_q <= 1'b1;
            sdaLevel_q <= 1'b1;
        end else begin
            if (sckAgree) sckLevel_q <= sckSync_q[2];
            if (sdaAgree) sdaLevel_q <= sdaSync_q[2];
        end
    end

    // Edges are one-cycle pulses against the last agreed level
    wire sckRise = sckAgree && sckSync_q[2] && !sckLevel_q;
    wire sckFall = sckAgree && !sckSync_q[2] && sckLevel_q;
    wire sdaRise = sdaAgree && sdaSync_q[2] && !sdaLevel_q;
    wire sdaFall = sdaAgree && !sdaSync_q[2] && sdaLevel_q;
    // A data change with the clock steady high is a marker
    // marker detection
    wire sckSteadyHigh = sckAgree && sckSync_q[2] && sckLevel_q;
    wire relSeen = sckSteadyHigh && sdaRise;
    wire cmdSeen = sckSteadyHigh && sdaFall;

    sbf_state_t state_q, state_d;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic       relFlag_q;
    logic       cmdFlag_q;
    logic       doneFlag_q;
    logic       matchFlag_q;
    logic       drive_q;
    logic       pendWrite_q;
    logic       overflow_q;
    sbf_byte_t  rxByte_q;
    logic       rxPush_q;
    logic       fifoInReady;

    wire        isAddr     = relFlag_q && cmdFlag_q;
    // Bits come from the agreed stage, in step with the clock edges
    wire [7:0]  nextShift  = {shift_q[6:0], sdaSync_q[2]};
    wire        lastBit    = (bitCnt_q == BIT_ACK - BIT_ONE);
    wire        doneEdge   = (state_q == ST_ACK) && sckRise;
    wire        addrHit    = (shift_q == slaveAddressRegister);
    wire        raiseDone  = doneEdge && (!wakeupSelectBit || (isAddr && addrHit));
    wire        markerAny  = relSeen || cmdSeen;
    wire        startXfer  = shiftRegisterWrite || pendWrite_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:  if (sckFall && serialUnitEnableBit) state_d = ST_SHIFT;
            ST_SHIFT: begin
                if (markerAny) state_d = ST_IDLE;
                else if (sckRise && lastBit) state_d = ST_ACK;
            end
            ST_ACK:   if (sckFall && bitCnt_q == BIT_DONE)
                          state_d = (busyEnableBit && !wakeupSelectBit) ? ST_BUSY : ST_IDLE;
            // ready on busy-enable cleared or write
            ST_BUSY:  if (!busyEnableBit || startXfer) state_d = ST_IDLE;
            default:  state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q  <= ST_IDLE;
            bitCnt_q <= BIT_ZERO;
        end else begin
            state_q <= state_d;
            if (state_q != ST_SHIFT && state_d == ST_SHIFT) bitCnt_q <= BIT_ZERO;
            else if (sckRise && state_q != ST_IDLE) bitCnt_q <= bitCnt_q + BIT_ONE;
        end
    end

    // marker history classifies the next byte
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            relFlag_q <= 1'b0;
            cmdFlag_q <= 1'b0;
        end else if (relSeen) begin
            relFlag_q <= 1'b1;
            cmdFlag_q <= 1'b0;
        end else if (cmdSeen) begin
            cmdFlag_q <= 1'b1;
        end else if (doneEdge) begin
            relFlag_q <= 1'b0;
            cmdFlag_q <= 1'b0;
        end
    end

    // Received bits land at rising clock; a register write loads at once in any other cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            shift_q     <= ALL_ONES;
            pendWrite_q <= 1'b0;
        end else begin
            if (state_q == ST_SHIFT && sckRise && !markerAny) shift_q <= nextShift;
            else if (shiftRegisterWrite) shift_q <= shiftRegisterWrData;
            // Writes during busy are kept until ready
            if (shiftRegisterWrite && state_q == ST_BUSY) pendWrite_q <= 1'b1;
            else if (state_q != ST_BUSY) pendWrite_q <= 1'b0;
        end
    end

    // Acknowledge low for one serial clock, then with busy enabled and wakeup off, busy low until ready
    // acknowledge drive
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            drive_q <= 1'b0;
        end else if (state_q == ST_ACK && sckFall && bitCnt_q == BIT_ACK) begin
            drive_q <= 1'b1;
        end else if (state_d == ST_IDLE || state_d == ST_SHIFT) begin
            drive_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            doneFlag_q  <= 1'b0;
            matchFlag_q <= 1'b0;
            rxByte_q    <= '0;
            rxPush_q    <= 1'b0;
            overflow_q  <= 1'b0;
        end else begin
            doneFlag_q  <= raiseDone;
            matchFlag_q <= doneEdge ? (isAddr && addrHit) : matchFlag_q;
            rxPush_q    <= raiseDone;
            if (raiseDone) begin
                rxByte_q.value <= shift_q;
                rxByte_q.kind  <= isAddr ? KIND_ADDRESS : (cmdFlag_q ? KIND_COMMAND : KIND_DATA);
            end
            // Sticky: no back-pressure on the wire, so a full FIFO drops bytes
            if (rxPush_q && !fifoInReady) overflow_q <= 1'b1;
        end
    end

    sbf_fifo #(
        .WIDTH ($bits(sbf_byte_t)),
        .DEPTH (FIFO_DEPTH)
    ) rxFifo (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .inData   (rxByte_q),
        .inValid  (rxPush_q),
        .inReady  (fifoInReady),
        .outData  (rxData),
        .outValid (rxValid),
        .outReady (rxReady)
    );

    // Open drain: only ever pull low, enable is active low
    assign busDataLineOut   = 1'b0;
    assign busDataLineOen   = !drive_q;
    assign shiftRegister    = shift_q;
    assign transferDoneFlag = doneFlag_q;
    assign busReleaseMarker = relFlag_q;
    assign commandMarker    = cmdFlag_q;
    assign addressMatch     = matchFlag_q;
    assign rxOverflow       = overflow_q;
endmodule
`default_nettype wire

// *** dv/sbf_slave_monitor.sv ***
// Port checker for the serial frame slave
`timescale 1ns/100ps
`default_nettype none
module sbf_slave_monitor
    import sbf_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic       busDataLineOut,
    input wire logic       busDataLineOen,
    input wire logic       busyEnableBit,
    input wire logic       wakeupSelectBit,
    input wire logic [7:0] shiftRegisterWrData,
    input wire logic       shiftRegisterWrite,
    input wire logic       transferDoneFlag,
    input wire logic       addressMatch,
    input wire logic       rxValid,
    input wire logic       rxOverflow
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire logic holdLow = !busDataLineOen && !wakeupSelectBit;
    chk_pull_zero: assert property (busDataLineOut == 1'b0)
        else $error("pull value not zero");
    chk_done_pulse: assert property (transferDoneFlag |=> !transferDoneFlag)
        else $error("done too long");
    chk_done_queued: assert property (transferDoneFlag |-> ##[1:4] rxValid)
        else $error("byte not queued");
    chk_wake_match: assert property (
        transferDoneFlag && wakeupSelectBit |-> ##[0:2] addressMatch)
        else $error("done without match");
    chk_ack_low: assert property (transferDoneFlag && !wakeupSelectBit |-> holdLow)
        else $error("no ack at done");
    chk_busy_hold: assert property (
        holdLow && busyEnableBit && !shiftRegisterWrite && !$past(shiftRegisterWrite)
        |=> !busDataLineOen)
        else $error("busy dropped");
    chk_write_ready: assert property (
        shiftRegisterWrite && shiftRegisterWrData == ALL_ONES |-> ##[1:8] busDataLineOen)
        else $error("write kept line low");
    chk_busy_clear: assert property ($fell(busyEnableBit) |-> ##[1:8] busDataLineOen)
        else $error("clear kept line low");
    chk_ovf_sticky: assert property (rxOverflow |=> rxOverflow)
        else $error("overflow dropped");
endmodule
bind sbf_slave sbf_slave_monitor sbf_slave_monitor_inst (.ref_clk, .rstn, .busDataLineOut,
    .busDataLineOen, .busyEnableBit, .wakeupSelectBit, .shiftRegisterWrData,
    .shiftRegisterWrite, .transferDoneFlag, .addressMatch, .rxValid, .rxOverflow);
`default_nettype wire

// *** dv/sbf_master_model.sv ***
// Bus master model: serial clock, markers and bytes
`timescale 1ns/100ps
`default_nettype none
module sbf_master_model
    import sbf_pkg::*;
(
    input  wire logic busLine,
    output logic      serialClock,
    output logic      masterBit,
    output logic      ackSeen
);
    localparam time HALF = 160;
    initial begin
        serialClock = 1'b1;
        masterBit = 1'b1;
        ackSeen = 1'b0;
    end
    task automatic waitReady();
        int n;
        #17;
        n = 0;
        while (busLine !== 1'b1 && n < 200) begin
            #HALF;
            n++;
        end
        if (busLine !== 1'b1) begin
            sbf_slave_tb.n_errors++;
            sbf_slave_tb.stop_test();
        end
    endtask
    task automatic markers(input sbf_kind_t kind);
        if (kind == KIND_ADDRESS) begin
            masterBit = 1'b0;
            #HALF masterBit = 1'b1;
            #HALF;
        end
        if (kind != KIND_DATA) begin
            masterBit = 1'b0;
            #HALF;
        end
    endtask
    task automatic shiftBits(input logic [7:0] value);
        // bits after the clock falls, then ack clock and a closing fall
        for (int i = 7; i > -3; i--) begin
            serialClock = 1'b0;
            #40 masterBit = (i < 0) ? 1'b1 : value[i];
            #(HALF - 40) serialClock = 1'b1;
            #HALF;
            if (i == -1) ackSeen = (busLine === 1'b0);
        end
    endtask
    task automatic sendByte(input sbf_kind_t kind, input logic [7:0] value);
        waitReady();
        markers(kind);
        shiftBits(value);
    endtask
endmodule
`default_nettype wire

// *** dv/sbf_slave_tb.sv ***
// Self-checking bench for the serial frame slave
`timescale 1ns/100ps
`default_nettype none
module sbf_slave_tb
    import sbf_pkg::*;
;
    logic       ref_clk, rstn, serialClockPin, masterBit, ackSeen, busDataLineOut;
    logic       busDataLineOen, serialUnitEnableBit, busyEnableBit, wakeupSelectBit;
    logic       shiftRegisterWrite, transferDoneFlag, addressMatch, busReleaseMarker;
    logic       commandMarker;
    logic       rxValid, rxReady, rxOverflow;
    logic [7:0] slaveAddressRegister, shiftRegisterWrData, shiftRegister;
    logic [9:0] rxData;
    int         n_errors, total_checks, doneCount;
    wire logic  busLine = masterBit & (busDataLineOen | busDataLineOut);
    sbf_slave sbf_slave_inst (.ref_clk, .rstn, .serialClockPin, .busDataLineIn(busLine),
        .busDataLineOut, .busDataLineOen, .serialUnitEnableBit, .busyEnableBit,
        .wakeupSelectBit, .slaveAddressRegister, .shiftRegisterWrData, .shiftRegisterWrite,
        .shiftRegister, .transferDoneFlag, .busReleaseMarker, .commandMarker,
        .addressMatch, .rxData, .rxValid, .rxReady, .rxOverflow);
    sbf_master_model sbf_master_model_inst (.busLine, .serialClock(serialClockPin),
        .masterBit, .ackSeen);
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (transferDoneFlag === 1'b1) doneCount++;
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic send(input sbf_kind_t k, input logic [7:0] v, input int expDone);
        int d;
        d = doneCount;
        sbf_master_model_inst.sendByte(k, v);
        tick(8);
        check("done count", 10'(expDone), 10'(doneCount - d));
        if (!wakeupSelectBit) check("ack", 10'h1, 10'(ackSeen));
        if (!busyEnableBit) check("ready", 10'h1, 10'(busLine));
    endtask
    task automatic pop(input logic [9:0] exp);
        int n;
        n = 0;
        while (rxValid !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        if (rxValid !== 1'b1) begin
            n_errors++;
            stop_test();
        end
        check("rx byte", exp, rxData);
        rxReady = 1'b1;
        tick(1);
        rxReady = 1'b0;
        // One edge with ready low keeps back-to-back pops from retoggling it
        tick(1);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        {rstn, shiftRegisterWrite, busyEnableBit, wakeupSelectBit, rxReady} = '0;
        serialUnitEnableBit = 1'b1;
        slaveAddressRegister = 8'h5a;
        shiftRegisterWrData = ALL_ONES;
        tick(16);
        rstn = 1'b1;
        tick(4);
        check("reset", 10'h2ff, {busDataLineOen, rxValid, shiftRegister});
        send(KIND_DATA, 8'ha5, 1);
        pop({KIND_DATA, 8'ha5});
        send(KIND_COMMAND, 8'h3c, 1);
        pop({KIND_COMMAND, 8'h3c});
        send(KIND_ADDRESS, 8'hc3, 1);
        pop({KIND_ADDRESS, 8'hc3});
        busyEnableBit = 1'b1;
        for (int i = 0; i < 2; i++) begin
            send(KIND_ADDRESS, 8'h81, 1);
            check("busy", 10'h0, 10'(busLine));
            shiftRegisterWrite = (i == 0);
            busyEnableBit = (i == 0);
            tick(1);
            shiftRegisterWrite = 1'b0;
            tick(10);
            check("released", 10'h1, 10'(busLine));
            pop({KIND_ADDRESS, 8'h81});
        end
        for (int i = 0; i < 9; i++) send(KIND_DATA, 8'(i), 1);
        check("overflow", 10'h1, 10'(rxOverflow));
        for (int i = 0; i < 8; i++) pop({KIND_DATA, 8'(i)});
        check("drained", 10'h0, 10'(rxValid));
        sbf_master_model_inst.waitReady();
        sbf_master_model_inst.markers(KIND_COMMAND);
        tick(8);
        check("cmd marker", 10'h1, 10'({busReleaseMarker, commandMarker}));
        sbf_master_model_inst.shiftBits(8'h99);
        tick(8);
        pop({KIND_COMMAND, 8'h99});
        sbf_master_model_inst.waitReady();
        sbf_master_model_inst.markers(KIND_ADDRESS);
        tick(8);
        check("addr markers", 10'h3, 10'({busReleaseMarker, commandMarker}));
        sbf_master_model_inst.shiftBits(8'h66);
        tick(8);
        check("markers cleared", 10'h0, 10'({busReleaseMarker, commandMarker}));
        pop({KIND_ADDRESS, 8'h66});
        wakeupSelectBit = 1'b1;
        send(KIND_ADDRESS, 8'h11, 0);
        send(KIND_ADDRESS, 8'h5a, 1);
        check("match", 10'h1, 10'(addressMatch));
        stop_test();
    end
endmodule
`default_nettype wire
